// >>> cfg_load_pkg.sv
package cfg_load_pkg;

  // ---------------------------------------------------------------
  // Pin bundle layout
  // ---------------------------------------------------------------
  localparam int PIN_W       = 17;
  localparam int PIN_CLK     = 0;
  localparam int PIN_BYTE_LO = 1;
  localparam int PIN_BYTE_HI = 8;
  localparam int PIN_WS      = 9;
  localparam int PIN_RS      = 10;
  localparam int PIN_CE      = 11;
  localparam int PIN_RESTART = 12;
  localparam int PIN_STATUS  = 13;
  localparam int PIN_DONE    = 14;
  localparam int PIN_SCH_LO  = 15;
  localparam int PIN_SCH_HI  = 16;

  // ---------------------------------------------------------------
  // Data path
  // ---------------------------------------------------------------
  localparam int          BYTE_W    = 8;
  localparam int          READY_BIT = 7;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [2:0]  BIT_ZERO  = 3'h0;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ   = 200;
  localparam int BUSY_NS     = 40;
  localparam int BUSY_CYCLES = (BUSY_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0] BUSY_LOAD = 4'(BUSY_CYCLES);
  localparam logic [3:0] BUSY_IDLE = 4'h0;

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCHEME_SERIAL = 2'h0,
    SCHEME_FAST   = 2'h1,
    SCHEME_ASYNC  = 2'h2,
    SCHEME_NONE   = 2'h3
  } scheme_e;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_INIT  = 3'h2,
    ST_USER  = 3'h3,
    ST_ERROR = 3'h4
  } load_state_e;

endpackage

// >>> pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  logic [W-1:0] rise;

  modport sampler (
    input  raw,
    output synced,
    output rise
  );
  modport user (
    output raw,
    input  synced,
    input  rise
  );
endinterface

// >>> pin_sampler.sv
`timescale 1ns/1ps
module pin_sampler #(
  parameter int W = 1
) (
  input wire logic   clock,  // System clock.
  input wire logic   rst_b,  // Synchronous reset, active low.
  pin_sync_if.sampler pins   // Raw pins in, synced levels and edges out.
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser with edge finder
  // ---------------------------------------------------------------
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // Only sync_reg samples meta_reg; edges come from later stages.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pins.raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign pins.synced = sync_reg;
  assign pins.rise   = sync_reg & ~prev_reg;

endmodule

// >>> config_data_input_port.sv
// What this block does
// - Drive chain pass-out low once configured.
// - Capture data on rising load clock edges.
// - Serial schemes: one bit per clock.
// - Parallel schemes: one byte per transfer.
// - Ignore load clock and serial line after configuration.
// - Serial schemes: upper data lines left undriven.
// - After parallel load, upper lines become user pins.
// - Async scheme: latch byte on write strobe rise.
// - Read strobe low shows ready on top line.
// - Non-async schemes: strobes and readback undriven.
// - After async load, strobes and top line user pins.
// - Ready high when free, low while busy.
// - Completion flag low until all data received.
// - Pull error line low on configuration error.
// - Restart low discards; returning high reloads.
`timescale 1ns/1ps
module config_data_input_port #(
  parameter int CONFIG_BYTES = 1024,
  parameter int INIT_CYCLES  = 16
) (
  input  wire logic       clock,                   // 200 MHz clock.
  input  wire logic       rst_b,                   // Sync reset, low.
  input  wire logic [1:0] scheme_select,           // Scheme strap pins.
  input  wire logic       chain_select_low,        // Chain select, low.
  input  wire logic       restart_b,               // Restart, low.
  input  wire logic       load_bit_clock,          // Load data clock.
  input  wire logic       serial_load_line,        // Data line 0.
  input  wire logic [5:0] upper_data_in,           // Data lines 6..1.
  input  wire logic       ready_readback_line_in,  // Data line 7 in.
  output logic            ready_readback_line_out, // Data line 7 out.
  output logic            ready_readback_line_oe_b,// Line 7 drive, low.
  input  wire logic       write_strobe_b,          // Write strobe, low.
  input  wire logic       status_read_strobe_b,    // Read strobe, low.
  input  wire logic       error_status_in,         // Error line level.
  output logic            error_status_out,        // Error line value.
  output logic            error_status_oe_b,       // Error drive, low.
  input  wire logic       load_complete_flag_in,   // Done line level.
  output logic            load_complete_flag_out,  // Done line value.
  output logic            load_complete_flag_oe_b, // Done drive, low.
  output logic            chain_pass_out,          // Next chain select.
  output logic            user_pins_released,      // Pins to user logic.
  output logic [7:0]      config_byte,             // Assembled byte.
  output logic            config_byte_valid        // Byte strobe.
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (CONFIG_BYTES < 1) begin : g_bad_bytes
    $error("CONFIG_BYTES must be at least one");
  end
  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
    $error("INIT_CYCLES must lie between 1 and 65535");
  end

  localparam logic [31:0] LAST_BYTE = 32'(CONFIG_BYTES - 1);
  localparam logic [15:0] LAST_INIT = 16'(INIT_CYCLES - 1);

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  pin_sync_if #(.W(cfg_load_pkg::PIN_W)) pins ();

  assign pins.raw = {scheme_select,
                     load_complete_flag_in,
                     error_status_in,
                     restart_b,
                     chain_select_low,
                     status_read_strobe_b,
                     write_strobe_b,
                     ready_readback_line_in,
                     upper_data_in,
                     serial_load_line,
                     load_bit_clock};

  pin_sampler #(.W(cfg_load_pkg::PIN_W)) u_sampler (
    .clock (clock),
    .rst_b (rst_b),
    .pins  (pins)
  );

  // ---------------------------------------------------------------
  // Decoded pin levels
  // ---------------------------------------------------------------
  cfg_load_pkg::scheme_e     scheme_reg;
  cfg_load_pkg::load_state_e state_reg;
  cfg_load_pkg::load_state_e state_next;

  wire [7:0] line_byte   = pins.synced[cfg_load_pkg::PIN_BYTE_HI:
                                       cfg_load_pkg::PIN_BYTE_LO];
  wire       line_serial = pins.synced[cfg_load_pkg::PIN_BYTE_LO];
  wire       clk_rise    = pins.rise[cfg_load_pkg::PIN_CLK];
  wire       ws_rise     = pins.rise[cfg_load_pkg::PIN_WS];
  wire       rs_low      = ~pins.synced[cfg_load_pkg::PIN_RS];
  wire       ce_ok       = ~pins.synced[cfg_load_pkg::PIN_CE];
  wire       restart_hi  = pins.synced[cfg_load_pkg::PIN_RESTART];
  wire       status_low  = ~pins.synced[cfg_load_pkg::PIN_STATUS];
  wire       done_high   = pins.synced[cfg_load_pkg::PIN_DONE];
  wire [1:0] scheme_pins = pins.synced[cfg_load_pkg::PIN_SCH_HI:
                                       cfg_load_pkg::PIN_SCH_LO];

  wire is_serial = (scheme_reg == cfg_load_pkg::SCHEME_SERIAL);
  wire is_fast   = (scheme_reg == cfg_load_pkg::SCHEME_FAST);
  wire is_async  = (scheme_reg == cfg_load_pkg::SCHEME_ASYNC);
  wire loading   = (state_reg == cfg_load_pkg::ST_LOAD);

  // ---------------------------------------------------------------
  // Data capture
  // ---------------------------------------------------------------
  logic [7:0]  shift_reg;
  logic [2:0]  bit_cnt_reg;
  logic [3:0]  busy_cnt_reg;
  logic [31:0] byte_cnt_reg;
  logic [15:0] init_cnt_reg;

  wire accept    = loading && ce_ok;
  wire take_bit  = accept && is_serial && clk_rise;
  wire ser_done  = take_bit && (bit_cnt_reg == cfg_load_pkg::LAST_BIT);
  wire take_fast = accept && is_fast && clk_rise;
  wire ready_now = (busy_cnt_reg == cfg_load_pkg::BUSY_IDLE);
  wire take_ws   = accept && is_async && ws_rise && ready_now;
  wire take_byte = ser_done || take_fast || take_ws;
  wire last_byte = take_byte && (byte_cnt_reg == LAST_BYTE);

  // Serial data arrives least significant bit first.
  wire [7:0] shifted   = {line_serial, shift_reg[7:1]};
  wire [7:0] byte_next = ser_done ? shifted : line_byte;

  wire [3:0] busy_next = take_ws ? cfg_load_pkg::BUSY_LOAD :
                         ready_now ? cfg_load_pkg::BUSY_IDLE :
                         busy_cnt_reg - 4'h1;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shift_reg    <= cfg_load_pkg::BYTE_ZERO;
      bit_cnt_reg  <= cfg_load_pkg::BIT_ZERO;
      busy_cnt_reg <= cfg_load_pkg::BUSY_IDLE;
    end else begin
      busy_cnt_reg <= busy_next;
      if (!loading) begin
        bit_cnt_reg <= cfg_load_pkg::BIT_ZERO;
      end else if (take_bit) begin
        shift_reg   <= shifted;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      byte_cnt_reg <= '0;
    end else if (!loading) begin
      byte_cnt_reg <= '0;
    end else if (take_byte) begin
      byte_cnt_reg <= byte_cnt_reg + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Load sequencer
  // ---------------------------------------------------------------
  wire init_over = (init_cnt_reg == LAST_INIT) && done_high;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cfg_load_pkg::ST_HOLD: begin
        if (restart_hi) begin
          state_next = cfg_load_pkg::ST_LOAD;
        end
      end
      cfg_load_pkg::ST_LOAD: begin
        if (status_low) begin
          state_next = cfg_load_pkg::ST_ERROR;
        end else if (last_byte) begin
          state_next = cfg_load_pkg::ST_INIT;
        end
      end
      cfg_load_pkg::ST_INIT: begin
        if (status_low) begin
          state_next = cfg_load_pkg::ST_ERROR;
        end else if (init_over) begin
          state_next = cfg_load_pkg::ST_USER;
        end
      end
      cfg_load_pkg::ST_USER: begin
        state_next = cfg_load_pkg::ST_USER;
      end
      cfg_load_pkg::ST_ERROR: begin
        state_next = cfg_load_pkg::ST_ERROR;
      end
      default: begin
        state_next = cfg_load_pkg::ST_HOLD;
      end
    endcase
    if (!restart_hi) begin
      state_next = cfg_load_pkg::ST_HOLD;
    end
  end

  wire hold_done_low = (state_next == cfg_load_pkg::ST_HOLD) ||
                       (state_next == cfg_load_pkg::ST_LOAD) ||
                       (state_next == cfg_load_pkg::ST_ERROR);
  wire in_user       = (state_next == cfg_load_pkg::ST_USER);
  wire in_error      = (state_next == cfg_load_pkg::ST_ERROR);
  wire drive_ready   = is_async && rs_low &&
                       ((state_next == cfg_load_pkg::ST_LOAD) ||
                        (state_next == cfg_load_pkg::ST_INIT));

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg    <= cfg_load_pkg::ST_HOLD;
      scheme_reg   <= cfg_load_pkg::SCHEME_SERIAL;
      init_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == cfg_load_pkg::ST_HOLD) begin
        scheme_reg <= cfg_load_pkg::scheme_e'(scheme_pins);
      end
      if (state_reg != cfg_load_pkg::ST_INIT) begin
        init_cnt_reg <= '0;
      end else if (init_cnt_reg != LAST_INIT) begin
        init_cnt_reg <= init_cnt_reg + 16'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      config_byte              <= cfg_load_pkg::BYTE_ZERO;
      config_byte_valid        <= 1'b0;
      chain_pass_out           <= 1'b1;
      user_pins_released       <= 1'b0;
      load_complete_flag_out   <= 1'b0;
      load_complete_flag_oe_b  <= 1'b0;
      error_status_out         <= 1'b0;
      error_status_oe_b        <= 1'b1;
      ready_readback_line_out  <= 1'b1;
      ready_readback_line_oe_b <= 1'b1;
    end else begin
      config_byte_valid        <= take_byte;
      if (take_byte) begin
        config_byte <= byte_next;
      end
      chain_pass_out           <= ~in_user;
      user_pins_released       <= in_user;
      load_complete_flag_out   <= 1'b0;
      load_complete_flag_oe_b  <= ~hold_done_low;
      error_status_out         <= 1'b0;
      error_status_oe_b        <= ~in_error;
      ready_readback_line_out  <= (busy_next == cfg_load_pkg::BUSY_IDLE);
      ready_readback_line_oe_b <= ~drive_ready;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_pass_out_user: assert property (
    chain_pass_out == (state_reg != cfg_load_pkg::ST_USER))
    else $error("chain pass-out disagrees with user state");

  chk_fast_clock_take: assert property (
    take_fast |=> config_byte_valid && config_byte == $past(line_byte))
    else $error("fast scheme clock edge did not load a byte");

  chk_serial_bit_order: assert property (
    (config_byte_valid && is_serial) |->
      config_byte[7] == $past(line_serial))
    else $error("serial byte top bit is not the last bit taken");

  chk_serial_eight_edges: assert property (
    (take_bit && bit_cnt_reg == cfg_load_pkg::BIT_ZERO) |=>
      !config_byte_valid)
    else $error("serial byte emitted before eight bits");

  chk_async_strobe_take: assert property (
    take_ws |=> config_byte_valid ##0 !ready_readback_line_out)
    else $error("write strobe rise did not latch a byte");

  chk_busy_window: assert property (
    take_ws |=> (busy_cnt_reg != cfg_load_pkg::BUSY_IDLE) [*8]
      ##1 (busy_cnt_reg == cfg_load_pkg::BUSY_IDLE))
    else $error("busy window length is wrong");

  chk_ready_drive: assert property (
    !ready_readback_line_oe_b |-> is_async && $past(rs_low))
    else $error("ready line driven outside async read");

  chk_done_held_low: assert property (
    (state_reg == cfg_load_pkg::ST_LOAD) |-> !load_complete_flag_oe_b)
    else $error("completion flag released during load");

  chk_error_drive: assert property (
    (loading && status_low && restart_hi) |=> ##1 !error_status_oe_b)
    else $error("error line not pulled low after error");

  chk_restart_hold: assert property (
    !restart_hi |=> state_reg == cfg_load_pkg::ST_HOLD)
    else $error("restart low did not discard the load");

  chk_select_ignore: assert property (
    !ce_ok |=> !config_byte_valid)
    else $error("data taken while chain select high");

  chk_strobe_once: assert property (
    take_ws |=> byte_cnt_reg == $past(byte_cnt_reg) + 32'h1)
    else $error("write strobe edge not counted once");

  cov_serial_byte: cover property (config_byte_valid && is_serial);
  cov_async_byte:  cover property (config_byte_valid && is_async);
  cov_reach_user:  cover property (state_reg == cfg_load_pkg::ST_USER);
  cov_error_seen:  cover property (state_reg == cfg_load_pkg::ST_ERROR);

endmodule

// >>> cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic       ready_readback_line_out,  // Device line 7 value.
  input  wire logic       ready_readback_line_oe_b, // Device drives 7, low.
  input  wire logic       error_status_out,         // Device error value.
  input  wire logic       error_status_oe_b,        // Device error drive.
  input  wire logic       load_complete_flag_out,   // Device done value.
  input  wire logic       load_complete_flag_oe_b,  // Device done drive.
  output logic            load_bit_clock,           // Load clock pin.
  output logic            serial_load_line,         // Data line 0.
  output logic [5:0]      upper_data_in,            // Data lines 6..1.
  output logic            ready_readback_line_in,   // Line 7 wire level.
  output logic            write_strobe_b,           // Write strobe.
  output logic            status_read_strobe_b,     // Read strobe.
  output logic            error_status_in,          // Error wire level.
  output logic            load_complete_flag_in     // Done wire level.
);
  logic host_line7;
  logic err_pull;
  int   half;

  // ---------------------------------------------------------------
  // Wired pins
  // ---------------------------------------------------------------
  // Both open-drain lines have pull-ups.
  assign error_status_in = ((!error_status_oe_b && !error_status_out) ||
                            err_pull) ? 1'b0 : 1'b1;
  assign load_complete_flag_in =
    (!load_complete_flag_oe_b && !load_complete_flag_out) ? 1'b0 : 1'b1;
  assign ready_readback_line_in =
    !ready_readback_line_oe_b ? ready_readback_line_out : host_line7;

  initial begin
    load_bit_clock = 1'b0;
    serial_load_line = 1'b0;
    upper_data_in = 6'h00;
    host_line7 = 1'b0;
    write_strobe_b = 1'b1;
    status_read_strobe_b = 1'b1;
    err_pull = 1'b0;
    half = 32;
  end

  // ---------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------
  // The upper lines wander during serial bits, since they carry no data.
  task automatic send_serial(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      serial_load_line = b[i];
      upper_data_in = ~upper_data_in;
      host_line7 = ~host_line7;
      #half load_bit_clock = 1'b1;
      #half load_bit_clock = 1'b0;
    end
  endtask

  // The lines wander once the hold time after the strobing edge is over.
  task automatic send_fast(input logic [7:0] b);
    {host_line7, upper_data_in, serial_load_line} = b;
    #half load_bit_clock = 1'b1;
    #16 {host_line7, upper_data_in, serial_load_line} = ~b;
    #(half - 16) load_bit_clock = 1'b0;
  endtask

  task automatic send_async(input logic [7:0] b);
    {host_line7, upper_data_in, serial_load_line} = b;
    #half write_strobe_b = 1'b0;
    #half write_strobe_b = 1'b1;
    #16 {host_line7, upper_data_in, serial_load_line} = ~b;
    #4;
  endtask

  // Parked load clock level after a load; data line held at a fixed level.
  task automatic park(input logic clk_level);
    load_bit_clock = clk_level;
    serial_load_line = 1'b0;
  endtask
endmodule

// >>> tb_config_data_input_port.sv
`timescale 1ns/1ps
module tb_config_data_input_port;
  localparam int NBYTES = 4;
  localparam int NINIT  = 2;
  localparam logic [7:0] PAT [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};

  logic       clock;
  logic       rst_b;
  logic [1:0] scheme_select;
  logic       chain_select_low;
  logic       restart_b;
  logic       load_bit_clock;
  logic       serial_load_line;
  logic [5:0] upper_data_in;
  logic       ready_readback_line_in;
  logic       ready_readback_line_out;
  logic       ready_readback_line_oe_b;
  logic       write_strobe_b;
  logic       status_read_strobe_b;
  logic       error_status_in;
  logic       error_status_out;
  logic       error_status_oe_b;
  logic       load_complete_flag_in;
  logic       load_complete_flag_out;
  logic       load_complete_flag_oe_b;
  logic       chain_pass_out;
  logic       user_pins_released;
  logic [7:0] config_byte;
  logic       config_byte_valid;
  logic [7:0] got [$];
  int         n_mismatch;
  int         n_checks;

  config_data_input_port #(
    .CONFIG_BYTES(NBYTES),
    .INIT_CYCLES (NINIT)
  ) config_data_input_port_i (
    .clock, .rst_b, .scheme_select, .chain_select_low, .restart_b,
    .load_bit_clock, .serial_load_line, .upper_data_in,
    .ready_readback_line_in, .ready_readback_line_out,
    .ready_readback_line_oe_b, .write_strobe_b, .status_read_strobe_b,
    .error_status_in, .error_status_out, .error_status_oe_b,
    .load_complete_flag_in, .load_complete_flag_out,
    .load_complete_flag_oe_b, .chain_pass_out, .user_pins_released,
    .config_byte, .config_byte_valid
  );

  cfg_host_model cfg_host_model_i (
    .ready_readback_line_out, .ready_readback_line_oe_b,
    .error_status_out, .error_status_oe_b, .load_complete_flag_out,
    .load_complete_flag_oe_b, .load_bit_clock, .serial_load_line,
    .upper_data_in, .ready_readback_line_in, .write_strobe_b,
    .status_read_strobe_b, .error_status_in, .load_complete_flag_in
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (config_byte_valid === 1'b1) begin
      got.push_back(config_byte);
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic start(input logic [1:0] s, input logic clk_level);
    @(negedge clock);
    cfg_host_model_i.park(clk_level);
    scheme_select = s;
    restart_b = 1'b0;
    repeat (6) @(negedge clock);
    restart_b = 1'b1;
    repeat (8) @(negedge clock);
    got.delete();
    check("pass out held", chain_pass_out, 1'b1);
    check("done held low", load_complete_flag_oe_b, 1'b0);
    check("error released", error_status_oe_b, 1'b1);
    check("done value", load_complete_flag_out, 1'b0);
  endtask

  task automatic check_bytes(input int n);
    repeat (4) @(negedge clock);
    check("byte count", 8'(got.size()), 8'(n));
    for (int i = 0; i < n && i < got.size(); i++) begin
      check("config byte", got[i], PAT[i]);
    end
  endtask

  task automatic expect_user();
    repeat (NINIT + 10) @(negedge clock);
    check("pass out", chain_pass_out, 1'b0);
    check("user pins", user_pins_released, 1'b1);
    check("done released", load_complete_flag_oe_b, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_serial();
    start(2'h0, 1'b0);
    cfg_host_model_i.status_read_strobe_b = 1'b0;
    for (int i = 0; i < 3; i++) begin
      cfg_host_model_i.send_serial(PAT[i], 8);
    end
    check("line 7 undriven", ready_readback_line_oe_b, 1'b1);
    check("done mid load", load_complete_flag_oe_b, 1'b0);
    check("pass out mid load", chain_pass_out, 1'b1);
    cfg_host_model_i.status_read_strobe_b = 1'b1;
    cfg_host_model_i.send_serial(PAT[3], 8);
    check_bytes(NBYTES);
    expect_user();
    cfg_host_model_i.send_serial(8'hFF, 8);
    @(negedge clock);
    cfg_host_model_i.park(1'b0);
    repeat (8) @(negedge clock);
    check("bytes after user", 8'(got.size()), 8'h04);
    check("still user", user_pins_released, 1'b1);
  endtask

  task automatic t_fast();
    start(2'h1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cfg_host_model_i.send_fast(PAT[i]);
    end
    check_bytes(NBYTES);
    expect_user();
  endtask

  // A strobe within the busy time of the third byte must be ignored.
  task automatic t_async();
    start(2'h2, 1'b1);
    cfg_host_model_i.status_read_strobe_b = 1'b0;
    fork
      cfg_host_model_i.send_async(PAT[0]);
      begin
        @(posedge write_strobe_b);
        repeat (5) @(posedge clock);
        #1 check("busy level", ready_readback_line_in, 1'b0);
        check("line 7 drive", ready_readback_line_oe_b, 1'b0);
        repeat (10) @(posedge clock);
        #1 check("ready level", ready_readback_line_in, 1'b1);
        check("ready value", ready_readback_line_out, 1'b1);
      end
    join
    cfg_host_model_i.status_read_strobe_b = 1'b1;
    cfg_host_model_i.send_async(PAT[1]);
    cfg_host_model_i.send_async(PAT[2]);
    cfg_host_model_i.half = 6;
    cfg_host_model_i.send_async(8'h11);
    cfg_host_model_i.half = 32;
    cfg_host_model_i.send_async(PAT[3]);
    check_bytes(NBYTES);
    expect_user();
  endtask

  task automatic t_error();
    start(2'h1, 1'b0);
    cfg_host_model_i.send_fast(PAT[0]);
    @(negedge clock);
    cfg_host_model_i.err_pull = 1'b1;
    repeat (4) @(negedge clock);
    cfg_host_model_i.err_pull = 1'b0;
    repeat (4) @(negedge clock);
    check("error pulled", error_status_oe_b, 1'b0);
    check("error value", error_status_out, 1'b0);
    for (int i = 1; i < 4; i++) begin
      cfg_host_model_i.send_fast(PAT[i]);
    end
    repeat (NINIT + 10) @(negedge clock);
    check("done after error", load_complete_flag_oe_b, 1'b0);
    check("no pass out", chain_pass_out, 1'b1);
  endtask

  task automatic t_chain_restart();
    start(2'h3, 1'b0);
    cfg_host_model_i.send_serial(PAT[1], 8);
    check_bytes(0);
    start(2'h0, 1'b0);
    chain_select_low = 1'b1;
    cfg_host_model_i.send_serial(PAT[3], 8);
    @(negedge clock);
    chain_select_low = 1'b0;
    check_bytes(0);
    cfg_host_model_i.send_serial(PAT[2], 5);
    start(2'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cfg_host_model_i.send_serial(PAT[i], 8);
    end
    check_bytes(NBYTES);
    expect_user();
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rst_b = 1'b0;
    scheme_select = 2'h0;
    chain_select_low = 1'b0;
    restart_b = 1'b1;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (8) @(negedge clock);
    t_serial();
    t_fast();
    t_async();
    t_error();
    t_chain_restart();
    print_verdict();
  end

  // The scenarios need about 8 us; this allows more than ten times that.
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
